// File: rtl/hbp_pkg.sv
// Package for the host bus address and data port: widths, strap codes, states,
// and the packed carriers shared by the port front end and the testbench.
// Assumes one system clock; host pins are taken as synchronous to it, except select in asynchronous timing mode.
package hbp_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // Bus width strap codes
  localparam logic [1:0] WIDTH_32  = 2'h0;
  localparam logic [1:0] WIDTH_16  = 2'h1;
  localparam logic [1:0] WIDTH_8   = 2'h2;
  localparam logic [1:0] WIDTH_RSV = 2'h3;

  // Bus timing strap: 0 synchronous, 1 asynchronous
  localparam logic TIMING_SYNC  = 1'b0;
  localparam logic TIMING_ASYNC = 1'b1;

  // Clock source strap: 0 external, 1 internal
  localparam logic CLKSRC_EXT = 1'b0;

  // Byte lane enables per width
  localparam logic [3:0] LANES_32 = 4'hF;
  localparam logic [3:0] LANES_16 = 4'h3;
  localparam logic [3:0] LANES_8  = 4'h1;
  localparam logic [3:0] LANES_0  = 4'h0;

  // Cycles the stall output is held after an access is taken
  localparam int STALL_CYCLES = 2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_STALL = 2'b01,
    ST_XFER  = 2'b10
  } port_state_e;

  // Host control pins, active low
  typedef struct packed {
    logic select_n;
    logic write_n;
    logic out_en_n;
  } host_ctrl_s;

  // Strap levels
  typedef struct packed {
    logic       bus_timing_strap;
    logic       system_clock_source_strap;
    logic       stall_polarity_strap;
    logic [1:0] bus_width_strap;
  } straps_s;

endpackage : hbp_pkg

// File: rtl/host_bus_address_data_port.sv
// Host bus address and data port front end: captures the register address,
// applies the width strap, and drives or samples the data lines.
// Assumes the internal register file answers read data combinationally from
// the captured address; straps are caught once after reset release.
`timescale 1ns/1ps
module host_bus_address_data_port
#(
  parameter int ADDR_W = hbp_pkg::ADDR_W,
  parameter int DATA_W = hbp_pkg::DATA_W
)
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  // Straps
  input  wire hbp_pkg::straps_s  straps_i,
  // Host pins
  input  wire hbp_pkg::host_ctrl_s host_ctrl_i,
  input  wire logic [ADDR_W-1:0] host_addr_i,
  input  wire logic [DATA_W-1:0] host_data_i,
  output logic [DATA_W-1:0]      host_data_o,
  output logic [DATA_W-1:0]      host_data_oe_n_o,
  output logic                   stall_o,
  // Register side
  input  wire logic [DATA_W-1:0] reg_rdata_i,
  output logic [ADDR_W-1:0]      reg_addr_o,
  output logic                   reg_wr_o,
  output logic                   reg_rd_o,
  output logic [DATA_W-1:0]      reg_wdata_o,
  output logic [3:0]             reg_lanes_o,
  output logic                   strap_err_o
);

  // Address mask for the strapped width
  function automatic logic [ADDR_W-1:0] mask_addr(input logic [1:0] w,
                                                  input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] m;
    m = a;
    case (w)
      hbp_pkg::WIDTH_32: m[1:0] = 2'h0;
      hbp_pkg::WIDTH_16: m[0]   = 1'b0;
      default:           m      = a;
    endcase
    return m;
  endfunction : mask_addr

  // Byte lanes that take part for the strapped width
  function automatic logic [3:0] width_lanes(input logic [1:0] w);
    case (w)
      hbp_pkg::WIDTH_32: return hbp_pkg::LANES_32;
      hbp_pkg::WIDTH_16: return hbp_pkg::LANES_16;
      hbp_pkg::WIDTH_8:  return hbp_pkg::LANES_8;
      default:           return hbp_pkg::LANES_0;
    endcase
  endfunction : width_lanes

  // Strap capture
  logic             strap_ok_q;
  logic             strap_ok_d;
  hbp_pkg::straps_s straps_q;
  hbp_pkg::straps_s straps_d;
  logic             strap_err_q;
  logic             strap_err_d;

  // Synchronised select for asynchronous mode
  logic sel_sync_n;
  logic sel_prev_n_q;
  logic sel_prev_n_d;

  // Access state
  hbp_pkg::port_state_e state_q;
  hbp_pkg::port_state_e state_d;
  logic [1:0]           stall_cnt_q;
  logic [1:0]           stall_cnt_d;
  logic [ADDR_W-1:0]    addr_q;
  logic [ADDR_W-1:0]    addr_d;
  logic                 sel_prev_sync_n_q;
  logic                 sel_prev_sync_n_d;

  // Output flops
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] dout_d;
  logic [DATA_W-1:0] doe_n_q;
  logic [DATA_W-1:0] doe_n_d;
  logic              stall_q;
  logic              stall_d;
  logic              wr_q;
  logic              wr_d;
  logic              rd_q;
  logic              rd_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] wdata_d;

  logic       sel_active;
  logic       capture;
  logic [3:0] lanes;

  select_sync u_select_sync
  (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (reset_i),
    .select_n_i (host_ctrl_i.select_n),
    .select_n_o (sel_sync_n)
  );

  // Straps latched one cycle after reset release; never from reset itself
  always_comb
  begin
    strap_ok_d  = 1'b1;
    straps_d    = strap_ok_q ? straps_q : straps_i;
    strap_err_d = strap_err_q;
    if (!strap_ok_q)
    begin
      // Sync timing needs the external clock; reserved width is also flagged
      strap_err_d = ((straps_i.bus_timing_strap == hbp_pkg::TIMING_SYNC) &&
                     (straps_i.system_clock_source_strap != hbp_pkg::CLKSRC_EXT)) ||
                    (straps_i.bus_width_strap == hbp_pkg::WIDTH_RSV);
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      strap_ok_q  <= 1'b0;
      straps_q    <= '0;
      strap_err_q <= 1'b0;
    end
    else
    begin
      strap_ok_q  <= strap_ok_d;
      straps_q    <= straps_d;
      strap_err_q <= strap_err_d;
    end
  end

  assign lanes = width_lanes(straps_q.bus_width_strap);

  // Start of access: raw select edge in sync mode, synchronised edge otherwise.
  // The address is read straight from the pins; the host keeps it steady.
  always_comb
  begin
    sel_prev_n_d      = host_ctrl_i.select_n;
    sel_prev_sync_n_d = sel_sync_n;
    if (straps_q.bus_timing_strap == hbp_pkg::TIMING_SYNC)
    begin
      capture    = sel_prev_n_q && !host_ctrl_i.select_n;
      sel_active = !host_ctrl_i.select_n;
    end
    else
    begin
      capture    = sel_prev_sync_n_q && !sel_sync_n;
      sel_active = !sel_sync_n && !host_ctrl_i.select_n;
    end
    capture = capture && strap_ok_q && !strap_err_q;
  end

  // Access sequence: stall, then transfer until select released
  always_comb
  begin
    state_d     = state_q;
    stall_cnt_d = stall_cnt_q;
    addr_d      = addr_q;
    wr_d        = 1'b0;
    rd_d        = 1'b0;
    wdata_d     = wdata_q;
    case (state_q)
      hbp_pkg::ST_IDLE:
      begin
        if (capture)
        begin
          addr_d      = mask_addr(straps_q.bus_width_strap, host_addr_i);
          stall_cnt_d = 2'(hbp_pkg::STALL_CYCLES - 1);
          state_d     = hbp_pkg::ST_STALL;
        end
      end
      hbp_pkg::ST_STALL:
      begin
        if (!sel_active)
          state_d = hbp_pkg::ST_IDLE;
        else if (stall_cnt_q == 2'h0)
        begin
          state_d = hbp_pkg::ST_XFER;
          // Write strobe marks the access kind
          if (!host_ctrl_i.write_n)
          begin
            wr_d    = 1'b1;
            wdata_d = host_data_i & {{8{lanes[3]}}, {8{lanes[2]}},
                                     {8{lanes[1]}}, {8{lanes[0]}}};
          end
          else
            rd_d = 1'b1;
        end
        else
          stall_cnt_d = stall_cnt_q - 2'h1;
      end
      hbp_pkg::ST_XFER:
      begin
        if (!sel_active)
          state_d = hbp_pkg::ST_IDLE;
      end
      default: state_d = hbp_pkg::ST_IDLE;
    endcase
  end

  // Stall level and data drivers; drivers off unless selected and read enabled
  always_comb
  begin
    // Next strap value, so the first edge after reset already idles at the right level
    stall_d = straps_d.stall_polarity_strap ~^ (state_d == hbp_pkg::ST_STALL);
    dout_d  = dout_q;
    doe_n_d = '1;
    if (state_d == hbp_pkg::ST_XFER && sel_active && !host_ctrl_i.select_n &&
        !host_ctrl_i.out_en_n && host_ctrl_i.write_n)
    begin
      dout_d  = reg_rdata_i;
      doe_n_d = ~{{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q           <= hbp_pkg::ST_IDLE;
      stall_cnt_q       <= 2'h0;
      addr_q            <= '0;
      sel_prev_n_q      <= 1'b1;
      sel_prev_sync_n_q <= 1'b1;
      dout_q            <= '0;
      doe_n_q           <= '1;
      stall_q           <= 1'b0;
      wr_q              <= 1'b0;
      rd_q              <= 1'b0;
      wdata_q           <= '0;
    end
    else
    begin
      state_q           <= state_d;
      stall_cnt_q       <= stall_cnt_d;
      addr_q            <= addr_d;
      sel_prev_n_q      <= sel_prev_n_d;
      sel_prev_sync_n_q <= sel_prev_sync_n_d;
      dout_q            <= dout_d;
      doe_n_q           <= doe_n_d;
      stall_q           <= stall_d;
      wr_q              <= wr_d;
      rd_q              <= rd_d;
      wdata_q           <= wdata_d;
    end
  end

  assign host_data_o      = dout_q;
  assign host_data_oe_n_o = doe_n_q;
  assign stall_o          = stall_q;
  assign reg_addr_o       = addr_q;
  assign reg_wr_o         = wr_q;
  assign reg_rd_o         = rd_q;
  assign reg_wdata_o      = wdata_q;
  assign reg_lanes_o      = lanes;
  assign strap_err_o      = strap_err_q;

  // Checks
  property p_no_drive_deselected;
    @(posedge clk_sys_i) disable iff (reset_i)
      $past(host_ctrl_i.select_n) |-> (host_data_oe_n_o == '1);
  endproperty
  a_no_drive_deselected: assert property (p_no_drive_deselected) else $error("drive w/o select");

  property p_no_drive_oe_high;
    @(posedge clk_sys_i) disable iff (reset_i)
      $past(host_ctrl_i.out_en_n) |-> (host_data_oe_n_o == '1);
  endproperty
  a_no_drive_oe_high: assert property (p_no_drive_oe_high) else $error("drive w/o oe");

  property p_addr32;
    @(posedge clk_sys_i) disable iff (reset_i)
      (straps_q.bus_width_strap == hbp_pkg::WIDTH_32) |-> (reg_addr_o[1:0] == 2'h0);
  endproperty
  a_addr32: assert property (p_addr32) else $error("low bits kept in 32-bit");

  property p_addr16;
    @(posedge clk_sys_i) disable iff (reset_i)
      (straps_q.bus_width_strap == hbp_pkg::WIDTH_16) |-> (reg_addr_o[0] == 1'b0);
  endproperty
  a_addr16: assert property (p_addr16) else $error("bit0 kept in 16-bit");

  property p_sync_capture;
    @(posedge clk_sys_i) disable iff (reset_i)
      (capture && straps_q.bus_timing_strap == hbp_pkg::TIMING_SYNC)
        |=> (reg_addr_o == mask_addr(straps_q.bus_width_strap, $past(host_addr_i)));
  endproperty
  a_sync_capture: assert property (p_sync_capture) else $error("sync capture");

  property p_async_capture;
    @(posedge clk_sys_i) disable iff (reset_i)
      (capture && straps_q.bus_timing_strap == hbp_pkg::TIMING_ASYNC)
        |=> (state_q == hbp_pkg::ST_STALL);
  endproperty
  a_async_capture: assert property (p_async_capture) else $error("async capture");

  property p_stall_level;
    @(posedge clk_sys_i) disable iff (reset_i)
      (state_q == hbp_pkg::ST_STALL) |-> (stall_o == straps_q.stall_polarity_strap);
  endproperty
  a_stall_level: assert property (p_stall_level) else $error("stall level");

  property p_lanes16;
    @(posedge clk_sys_i) disable iff (reset_i)
      (straps_q.bus_width_strap == hbp_pkg::WIDTH_16) |-> (host_data_oe_n_o[31:16] == '1);
  endproperty
  a_lanes16: assert property (p_lanes16) else $error("upper lanes in 16-bit");

  property p_bad_straps;
    @(posedge clk_sys_i) disable iff (reset_i)
      strap_err_q |-> !reg_wr_o && !reg_rd_o;
  endproperty
  a_bad_straps: assert property (p_bad_straps) else $error("access with bad straps");

  c_write: cover property (@(posedge clk_sys_i) disable iff (reset_i) reg_wr_o);
  c_read: cover property (@(posedge clk_sys_i) disable iff (reset_i) reg_rd_o);
  c_drive: cover property (@(posedge clk_sys_i) disable iff (reset_i) host_data_oe_n_o != '1);

endmodule : host_bus_address_data_port

// File: rtl/select_sync.sv
// Two flop synchroniser for the active-low device select.
// Assumes the select pin may change at any time relative to clk_sys_i.
`timescale 1ns/1ps
module select_sync
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  // Pin and synchronised level
  input  wire logic select_n_i,
  output logic      select_n_o
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // First flop feeds only the second
  always_comb
  begin
    meta_d = select_n_i;
    sync_d = meta_q;
  end

  // Idle high so no access is seen during reset
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign select_n_o = sync_q;

endmodule : select_sync

// File: tb/host_model.sv
// Host processor model: drives select, strobes, address and write data.
// Assumes the bench resolves the data wire from the port's per-bit enables.
`timescale 1ns/1ps
module host_model
(
  // Clock
  input  wire logic                   clk_sys_i,
  // Host pins
  output hbp_pkg::host_ctrl_s         host_ctrl_o,
  output logic [hbp_pkg::ADDR_W-1:0]  host_addr_o,
  output logic [31:0]                 host_data_o
);
  // Idle bus at time zero
  initial
  begin
    host_ctrl_o = 3'h7;
    host_addr_o = 10'h000;
    host_data_o = 32'h0000_0000;
  end

  // Address and data are set once and held for the whole select window
  task start(input logic wr, input logic oe, input logic [9:0] a, input logic [31:0] d);
    @(negedge clk_sys_i);
    host_addr_o <= a;
    host_data_o <= wr ? d : ~host_data_o;
    host_ctrl_o <= {1'b0, ~wr, ~oe};
  endtask : start

  // Output enable is left as it was, to probe release on select alone
  task stop;
    @(negedge clk_sys_i);
    host_ctrl_o.select_n <= 1'b1;
    host_ctrl_o.write_n  <= 1'b1;
    host_data_o          <= ~host_data_o; // Released lines show no stale value
  endtask : stop
endmodule : host_model

// File: tb/tb_top.sv
// Testbench for the host bus port: strap sweep, reads, writes and aborts.
// Assumes a combinational register file model answering from reg_addr_o.
`timescale 1ns/1ps
module tb_top;
  logic                 clk_sys_i = 1'b0;
  logic                 reset_i   = 1'b1;
  hbp_pkg::straps_s     straps    = 5'h00;
  hbp_pkg::host_ctrl_s  ctrl;
  logic [9:0]           addr;
  logic [31:0]          hdata;
  logic [31:0]          bus;
  logic [31:0]          dout;
  logic [31:0]          oe_n;
  logic                 stall;
  logic [31:0]          rdata;
  logic [9:0]           raddr;
  logic                 wr;
  logic                 rd;
  logic [31:0]          wdata;
  logic [3:0]           lanes;
  logic                 err;
  logic [15:0]          seed = 16'h0019;
  int                   n_mismatch = 0;
  int                   n_compared = 0;
  hbp_pkg::straps_s     cfg [7] = '{5'h00, 5'h05, 5'h12, 5'h1C, 5'h15, 5'h08, 5'h13};

  always #5 clk_sys_i = ~clk_sys_i;

  // Wire level: a bit shows the port's value only where it drives
  assign bus   = (hdata & oe_n) | (dout & ~oe_n);
  assign rdata = {22'h0, raddr} ^ 32'h5A3C_96E1;

  host_model host_model_i (.clk_sys_i(clk_sys_i), .host_ctrl_o(ctrl), .host_addr_o(addr),
                           .host_data_o(hdata));

  host_bus_address_data_port host_bus_address_data_port_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .straps_i(straps), .host_ctrl_i(ctrl),
    .host_addr_i(addr), .host_data_i(bus), .host_data_o(dout), .host_data_oe_n_o(oe_n),
    .stall_o(stall), .reg_rdata_i(rdata), .reg_addr_o(raddr), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_lanes_o(lanes), .strap_err_o(err));

  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function logic [3:0] exp_lanes(input logic [1:0] w);
    return (w == hbp_pkg::WIDTH_32) ? hbp_pkg::LANES_32 : (w == hbp_pkg::WIDTH_16) ?
           hbp_pkg::LANES_16 : (w == hbp_pkg::WIDTH_8) ? hbp_pkg::LANES_8 : hbp_pkg::LANES_0;
  endfunction : exp_lanes

  // Low address bits that the width leaves out read as zero
  function logic [9:0] exp_addr(input logic [1:0] w, input logic [9:0] a);
    return (w == hbp_pkg::WIDTH_32) ? (a & 10'h3FC) : (w == hbp_pkg::WIDTH_16) ?
           (a & 10'h3FE) : a;
  endfunction : exp_addr

  function logic [31:0] lane_bits(input logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction : lane_bits

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task complete_run;
    $display("Compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // Straps only count when caught after reset, so each set gets a reset
  task do_reset(input hbp_pkg::straps_s s);
    @(negedge clk_sys_i);
    reset_i = 1'b1;
    straps  = s;
    repeat (4) @(negedge clk_sys_i);
    check("reset enables", oe_n, 32'hFFFF_FFFF);
    check("reset stall", stall, 1'b0);
    reset_i = 1'b0;
    // A stale strap level here would read as a stall with no access
    @(negedge clk_sys_i);
    check("idle stall after reset", stall, !s.stall_polarity_strap);
    @(negedge clk_sys_i);
  endtask : do_reset

  // Counts access pulses over a fixed window after a request
  task count_pulses(output int n);
    n = 0;
    repeat (10)
    begin
      @(posedge clk_sys_i);
      #1;
      if ((wr | rd) === 1'b1)
        n++;
    end
  endtask : count_pulses

  task access(input logic w, input logic oe);
    logic [9:0]  a;
    logic [31:0] d;
    logic [31:0] m;
    logic [9:0]  ea;
    logic        pol;
    logic        npol;
    int          lat;
    int          st;
    seed = lfsr(seed);
    a = seed[9:0];
    d[15:0] = seed;
    seed = lfsr(seed);
    d[31:16] = seed;
    pol  = straps.stall_polarity_strap;
    npol = ~pol;
    m    = lane_bits(exp_lanes(straps.bus_width_strap));
    ea   = exp_addr(straps.bus_width_strap, a);
    lat  = 0;
    st   = 0;
    host_model_i.start(w, oe, a, d);
    while (lat < 20 && (wr | rd) !== 1'b1)
    begin
      @(posedge clk_sys_i);
      #1;
      lat++;
      if (stall === pol)
        st++;
    end
    if (lat == 20)
    begin
      n_mismatch++;
      $display("Error access pulse never came");
      complete_run;
    end
    else
    begin
      // Capture edge, plus two synchroniser flops in async mode, then the stall
      check("latency", lat, (straps.bus_timing_strap ? 3 : 1) + hbp_pkg::STALL_CYCLES);
      check("stall cycles", st, hbp_pkg::STALL_CYCLES);
      check("address", raddr, ea);
      check("write pulse", wr, w);
      check("read pulse", rd, !w);
      if (w)
        check("write data", wdata, d & m);
      repeat (2) @(posedge clk_sys_i);
      #1;
      check("enables", oe_n, (oe && !w) ? ~m : 32'hFFFF_FFFF);
      if (oe && !w)
        check("read data", dout & m, ({22'h0, ea} ^ 32'h5A3C_96E1) & m);
      host_model_i.stop;
      repeat (2) @(posedge clk_sys_i);
      #1;
      check("released", oe_n, 32'hFFFF_FFFF);
      check("stall idle", stall, npol);
    end
  endtask : access

  // Main sequence: good strap sets, then the two refused sets
  initial
  begin
    int n;
    for (int i = 0; i < 5; i++)
    begin
      do_reset(cfg[i]);
      check("strap error", err, 1'b0);
      check("lanes", lanes, exp_lanes(cfg[i].bus_width_strap));
      for (int j = 0; j < 7; j++)
      begin
        seed = lfsr(seed);
        access(j < 4 ? j[0] : seed[0], j < 4 ? j[1] : seed[1]);
      end
      // Select dropped before the stall ends: no access
      seed = lfsr(seed);
      host_model_i.start(1'b0, 1'b1, seed[9:0], 32'h0000_0000);
      @(posedge clk_sys_i);
      host_model_i.stop;
      count_pulses(n);
      check("abort pulses", n, 0);
    end
    for (int i = 5; i < 7; i++)
    begin
      do_reset(cfg[i]);
      check("strap error", err, 1'b1);
      host_model_i.start(1'b0, 1'b1, 10'h155, 32'h0000_0000);
      count_pulses(n);
      host_model_i.stop;
      check("refused pulses", n, 0);
    end
    check("reserved lanes", lanes, hbp_pkg::LANES_0);
    complete_run;
  end
endmodule : tb_top
